// ==== ulmc_partner.sv ====
// ulmc_partner: far station; answers rts with cts, sends characters.
// assumes send, kind and slow change at rising edges.
`timescale 1ns/100ps
module ulmc_partner (
	input  wire logic                 i_clk,
	input  wire logic                 i_rst_n,
	input  wire logic                 i_rts,
	input  wire logic                 i_slow,
	input  wire logic                 i_send,
	input  wire logic [1:0]           i_kind,
	output logic                      o_cts,
	output ulmc_pkg::ulmc_rx_char_type o_rx_char
);
	logic [2:0] cnt;

	// cts follows rts after one or four cycles and drops one cycle after rts falls
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt <= 3'h0;
			o_cts <= 1'b0;
			o_rx_char <= '0;
		end else begin
			cnt <= i_rts ? ((cnt == 3'h4) ? cnt : cnt + 3'h1) : 3'h0;
			o_cts <= i_rts && (cnt >= (i_slow ? 3'h3 : 3'h0));
			o_rx_char.valid <= i_send;
			o_rx_char.error <= i_kind[0];
			o_rx_char.control <= i_kind[1];
			o_rx_char.ninth <= &i_kind;
			o_rx_char.data <= ~o_rx_char.data; // data churns outside a character
		end
	end
endmodule // ulmc_partner

// ==== ulmc_pkg.sv ====
// ulmc_pkg: constants, field layouts and carrier types of the serial
// line/mode configuration block.
// assumes a 32-bit avalon-mm slave port with byte addresses.
package ulmc_pkg;

	// register byte offsets; divisor bytes overlay when divisor access is on
	localparam logic [4:0] OFS_INTERNAL_MODE = 5'h00;
	localparam logic [4:0] OFS_LINE_CONFIGURE = 5'h04;
	localparam logic [4:0] OFS_TRANSMIT_MODE = 5'h08;
	localparam logic [4:0] OFS_STATUS = 5'h0C;
	localparam logic [4:0] OFS_CONTROL = 5'h10;
	localparam logic [4:0] OFS_GEN_A_DIVISOR_LOW = 5'h00;
	localparam logic [4:0] OFS_GEN_A_DIVISOR_HIGH = 5'h08;
	localparam logic [4:0] OFS_GEN_B_DIVISOR_LOW = 5'h0C;
	localparam logic [4:0] OFS_GEN_B_DIVISOR_HIGH = 5'h10;

	// internal_mode fields
	localparam int IMD_LOOP_ECHO_SELECT = 0;
	localparam int IMD_MULTIDROP_MODE = 1;
	localparam int IMD_RX_FIFO_DEPTH = 2;
	localparam int IMD_ACK_STYLE_SELECT = 3;
	localparam logic [7:0] IMD_WRITE_MASK = 8'h0F;
	localparam logic [7:0] IMD_RESET = 8'h0C;

	// line_configure fields
	localparam int LCR_CHAR_LENGTH_LOW = 0;
	localparam int LCR_CHAR_LENGTH_HIGH = 1;
	localparam int LCR_STOP_LENGTH_BIT_A = 2;
	localparam int LCR_PARITY_ENABLE = 3;
	localparam int LCR_PARITY_KIND_LOW = 4;
	localparam int LCR_PARITY_KIND_HIGH = 5;
	localparam int LCR_BREAK_FORCE = 6;
	localparam int LCR_DIVISOR_ACCESS = 7;
	localparam logic [7:0] LCR_WRITE_MASK = 8'hFF;
	localparam logic [7:0] LCR_RESET = 8'h00;

	// transmit_mode fields
	localparam int TMD_STOP_LENGTH_BIT_B = 0;
	localparam int TMD_STOP_LENGTH_BIT_C = 1;
	localparam int TMD_SOFTWARE_PARITY_FORCE = 2;
	localparam int TMD_FLOW_MODE_LOW = 3;
	localparam int TMD_FLOW_MODE_HIGH = 4;
	localparam int TMD_NINE_BIT_FLAG = 5;
	localparam int TMD_CONTROL_ECHO_DISABLE = 6;
	localparam int TMD_ERROR_ECHO_DISABLE = 7;
	localparam logic [7:0] TMD_WRITE_MASK = 8'hFF;
	localparam logic [7:0] TMD_RESET = 8'h00;

	// control register command bits (write only, read as zero)
	localparam int CTL_SOFT_RESET = 0;
	localparam int CTL_INT_CLEAR = 1;

	// interrupt output low time after acknowledge, and fixed limits
	localparam logic [1:0] INT_HOLD_CYCLES = 2'h2;
	localparam logic [3:0] RX_MIN_STOP_QUARTERS = 4'h3;
	localparam logic [2:0] RX_FIFO_DEPTH_FULL = 3'h4;
	localparam logic [2:0] RX_FIFO_DEPTH_SINGLE = 3'h1;

	typedef enum logic [2:0] {
		ULMC_PAR_NONE = 3'h0,
		ULMC_PAR_ODD = 3'h1,
		ULMC_PAR_EVEN = 3'h3,
		ULMC_PAR_HIGH = 3'h2,
		ULMC_PAR_LOW = 3'h6,
		ULMC_PAR_SOFT = 3'h7
	} ulmc_parity_type;

	typedef enum logic [1:0] {
		ULMC_FLOW_MANUAL = 2'h0,
		ULMC_FLOW_RESERVED = 2'h1,
		ULMC_FLOW_SEMI = 2'h2,
		ULMC_FLOW_AUTO = 2'h3
	} ulmc_flow_type;

	// configuration carried as one group
	typedef struct packed {
		logic [7:0]  internal_mode;
		logic [7:0]  line_configure;
		logic [7:0]  transmit_mode;
		logic [15:0] gen_a_divisor;
		logic [15:0] gen_b_divisor;
	} ulmc_cfg_type;

	// received character information from the receive path
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       ninth;
		logic       error;
		logic       control;
	} ulmc_rx_char_type;

endpackage

// ==== ulmc_top.sv ====
// ulmc_top: configuration registers and mode decode of a serial controller.
// assumes one 100 mhz clock, an avalon-mm master and a serial engine
// that reports idle, characters and interrupt status.
//
// What this block does
// RULE_01: registers always readable, written only when idle; control register commands are taken while busy too
// RULE_02: hardware or software reset restores all defaults
// RULE_03: acknowledge style bit picks manual or automatic
// RULE_04: automatic: interrupt low two cycles upon service
// RULE_05: manual: clear command, low two cycles, until set
// RULE_06: depth bit gives four-byte or single-byte receive fifo
// RULE_07: multidrop bit enables nine-bit address recognition
// RULE_08: loop select set: local or remote loopback
// RULE_09: loop select clear: echo off or on
// RULE_10: divisor access redirects accesses to divisor bytes
// RULE_11: break bit holds transmit data low
// RULE_12: parity bits select none, odd, even, high, low, software
// RULE_13: software parity bit passes through the fifo ports; this block only flags software parity on o_sw_parity
// RULE_14: three stop bits give quarter-bit stop length
// RULE_15: receiver accepts three-quarter stop or longer
// RULE_16: nine-bit flag and length bits give character size
// RULE_17: error echo disable drops errored characters from echo
// RULE_18: control echo disable drops control/address characters
// RULE_19: flow mode 00 host-driven, 01 reserved
// RULE_20: flow mode 10 cts gating, rts while enabled
// RULE_21: flow mode 11 cts gating, rts while data pending
// RULE_22: eight-bit registers, reserved bits read zero
//
// Chosen here: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
module ulmc_top #(
	parameter int         ADDR_W        = 5,
	parameter logic [15:0] GEN_A_DIV_RESET = 16'h0000,
	parameter logic [15:0] GEN_B_DIV_RESET = 16'h0000
) (
	input  wire logic                      i_clk,
	input  wire logic                      i_rst_n,
	input  wire logic [ADDR_W-1:0]         i_avs_address,
	input  wire logic                      i_avs_read,
	input  wire logic                      i_avs_write,
	input  wire logic [31:0]               i_avs_writedata,
	input  wire logic [3:0]                i_avs_byteenable,
	output logic      [31:0]               o_avs_readdata,
	output logic                           o_avs_waitrequest,
	input  wire logic                      i_device_idle,
	input  wire logic                      i_int_request,
	input  wire logic                      i_int_set_event,
	input  wire logic                      i_int_service,
	input  wire logic                      i_modem_loop_select,
	input  wire ulmc_pkg::ulmc_rx_char_type i_rx_char,
	input  wire logic [7:0]                i_station_address,
	input  wire logic                      i_tx_serial,
	input  wire logic                      i_tx_enable,
	input  wire logic                      i_tx_data_pending,
	input  wire logic                      i_cts_active,
	input  wire logic                      i_rts_manual,
	output ulmc_pkg::ulmc_cfg_type         o_cfg,
	output logic                           o_int,
	output logic                           o_txd,
	output logic                           o_rts,
	output logic                           o_tx_permit,
	output logic [2:0]                     o_rx_fifo_depth,
	output logic                           o_multidrop_mode,
	output logic                           o_address_char,
	output logic                           o_address_match,
	output logic                           o_local_loop,
	output logic                           o_remote_loop,
	output logic                           o_echo_char,
	output ulmc_pkg::ulmc_parity_type      o_parity_mode,
	output logic                           o_sw_parity,
	output logic [3:0]                     o_stop_quarters,
	output logic [3:0]                     o_rx_min_stop_quarters,
	output logic [3:0]                     o_char_bits
);

	// elaboration check: the register map needs five address bits
	generate
		if (ADDR_W < 5) begin : g_bad_addr
			$error("ulmc_top: ADDR_W must be at least 5");
		end
	endgenerate

	// whole state of the block
	typedef struct packed {
		ulmc_pkg::ulmc_cfg_type    cfg;
		logic                      waitrequest;
		logic [31:0]               readdata;
		logic                      write_refused;
		logic                      int_pending;
		logic [1:0]                int_hold;
		logic                      int_out;
		logic                      txd;
		logic                      rts;
		logic                      tx_permit;
		logic [2:0]                rx_fifo_depth;
		logic                      multidrop;
		logic                      address_char;
		logic                      address_match;
		logic                      local_loop;
		logic                      remote_loop;
		logic                      echo_char;
		ulmc_pkg::ulmc_parity_type parity_mode;
		logic                      sw_parity;
		logic [3:0]                stop_quarters;
		logic [3:0]                char_bits;
	} ulmc_state_type;

	ulmc_state_type state;
	ulmc_state_type next_state;

	// default configuration, shared by hardware and software reset
	function automatic ulmc_pkg::ulmc_cfg_type cfg_default();
		ulmc_pkg::ulmc_cfg_type c;
		c.internal_mode = ulmc_pkg::IMD_RESET;
		c.line_configure = ulmc_pkg::LCR_RESET;
		c.transmit_mode = ulmc_pkg::TMD_RESET;
		c.gen_a_divisor = GEN_A_DIV_RESET;
		c.gen_b_divisor = GEN_B_DIV_RESET;
		return c;
	endfunction

	localparam ulmc_state_type STATE_RESET = '{
		cfg: cfg_default(),
		waitrequest: 1'b1,
		readdata: 32'h0000_0000,
		write_refused: 1'b0,
		int_pending: 1'b0,
		int_hold: 2'h0,
		int_out: 1'b0,
		txd: 1'b1,
		rts: 1'b0,
		tx_permit: 1'b0,
		rx_fifo_depth: ulmc_pkg::RX_FIFO_DEPTH_SINGLE,
		multidrop: 1'b0,
		address_char: 1'b0,
		address_match: 1'b0,
		local_loop: 1'b0,
		remote_loop: 1'b0,
		echo_char: 1'b0,
		parity_mode: ulmc_pkg::ULMC_PAR_NONE,
		sw_parity: 1'b0,
		stop_quarters: 4'h4,
		char_bits: 4'h5
	};

	// register read mux, divisor overlay depends on divisor access
	function automatic logic [31:0] read_value(input ulmc_state_type s,
			input logic [4:0] a, input logic busy_int);
		logic [31:0] v;
		v = 32'h0000_0000;
		if (s.cfg.line_configure[ulmc_pkg::LCR_DIVISOR_ACCESS]) begin // RULE_10
			case (a)
				ulmc_pkg::OFS_GEN_A_DIVISOR_LOW:  v[7:0] = s.cfg.gen_a_divisor[7:0];
				ulmc_pkg::OFS_GEN_A_DIVISOR_HIGH: v[7:0] = s.cfg.gen_a_divisor[15:8];
				ulmc_pkg::OFS_GEN_B_DIVISOR_LOW:  v[7:0] = s.cfg.gen_b_divisor[7:0];
				ulmc_pkg::OFS_GEN_B_DIVISOR_HIGH: v[7:0] = s.cfg.gen_b_divisor[15:8];
				ulmc_pkg::OFS_LINE_CONFIGURE:     v[7:0] = s.cfg.line_configure;
				default:                          v = 32'h0000_0000;
			endcase
		end else begin
			case (a)
				ulmc_pkg::OFS_INTERNAL_MODE:  v[7:0] = s.cfg.internal_mode; // RULE_22
				ulmc_pkg::OFS_LINE_CONFIGURE: v[7:0] = s.cfg.line_configure;
				ulmc_pkg::OFS_TRANSMIT_MODE:  v[7:0] = s.cfg.transmit_mode;
				ulmc_pkg::OFS_STATUS:         v[3:0] = {s.write_refused, s.int_pending,
					busy_int, i_device_idle};
				default:                      v = 32'h0000_0000;
			endcase
		end
		return v;
	endfunction

	logic [4:0] addr;
	assign addr = i_avs_address[4:0];

	// next-state logic: bus slave, register writes, and line/mode decode
	always_comb begin
		ulmc_pkg::ulmc_cfg_type c;
		logic                   wr_take;
		logic                   lane0;
		logic                   divisor_access;
		logic [7:0]             wd;
		logic                   int_clear;
		logic                   soft_reset;
		logic [2:0]             pm;
		logic [2:0]             sbl;
		logic                   echo_on;
		logic                   int_src;
		c = state.cfg;
		next_state = state;
		wr_take = i_avs_write && !state.waitrequest;
		lane0 = i_avs_byteenable[0];
		divisor_access = state.cfg.line_configure[ulmc_pkg::LCR_DIVISOR_ACCESS];
		wd = i_avs_writedata[7:0];
		int_clear = 1'b0;
		soft_reset = 1'b0;
		pm = 3'h0;
		sbl = 3'h0;
		echo_on = 1'b0;
		int_src = 1'b0;

		// bus handshake: one wait cycle, then the request is taken
		if ((i_avs_read || i_avs_write) && state.waitrequest) begin
			next_state.waitrequest = 1'b0;
			next_state.readdata = read_value(state, addr, state.int_out); // RULE_01
		end else begin
			next_state.waitrequest = 1'b1;
		end

		// register writes other than control, refused while the line is busy
		if (wr_take && lane0) begin
			if (!divisor_access && addr == ulmc_pkg::OFS_CONTROL) begin
				soft_reset = wd[ulmc_pkg::CTL_SOFT_RESET];
				int_clear = wd[ulmc_pkg::CTL_INT_CLEAR];
			end else if (addr <= ulmc_pkg::OFS_GEN_B_DIVISOR_HIGH
					&& !(!divisor_access && addr == ulmc_pkg::OFS_STATUS)) begin
				next_state.write_refused = !i_device_idle; // RULE_01
				if (i_device_idle) begin
					case (addr)
						ulmc_pkg::OFS_LINE_CONFIGURE:
							c.line_configure = wd & ulmc_pkg::LCR_WRITE_MASK;
						ulmc_pkg::OFS_INTERNAL_MODE: begin
							if (divisor_access) begin
								c.gen_a_divisor[7:0] = wd; // RULE_10
							end else begin
								c.internal_mode = wd & ulmc_pkg::IMD_WRITE_MASK; // RULE_22
							end
						end
						ulmc_pkg::OFS_TRANSMIT_MODE: begin
							if (divisor_access) begin
								c.gen_a_divisor[15:8] = wd; // RULE_10
							end else begin
								c.transmit_mode = wd & ulmc_pkg::TMD_WRITE_MASK;
							end
						end
						ulmc_pkg::OFS_GEN_B_DIVISOR_LOW: c.gen_b_divisor[7:0] = wd;
						ulmc_pkg::OFS_GEN_B_DIVISOR_HIGH: c.gen_b_divisor[15:8] = wd;
						default: c = state.cfg;
					endcase
				end
			end
		end
		if (soft_reset) begin
			c = cfg_default(); // RULE_02
			next_state.write_refused = 1'b0;
		end
		next_state.cfg = c;

		// interrupt acknowledge: hold low two cycles, then follow the source
		if (state.cfg.internal_mode[ulmc_pkg::IMD_ACK_STYLE_SELECT]) begin // RULE_03
			next_state.int_pending = 1'b0;
			int_src = i_int_request;
			if (i_int_service) begin
				next_state.int_hold = ulmc_pkg::INT_HOLD_CYCLES; // RULE_04
			end else if (state.int_hold != 2'h0) begin
				next_state.int_hold = state.int_hold - 2'h1;
			end
		end else begin
			// a set event in the clearing cycle survives the clear
			next_state.int_pending = i_int_set_event || (state.int_pending && !int_clear);
			int_src = state.int_pending;
			if (int_clear) begin
				next_state.int_hold = ulmc_pkg::INT_HOLD_CYCLES; // RULE_05
			end else if (state.int_hold != 2'h0) begin
				next_state.int_hold = state.int_hold - 2'h1;
			end
		end
		next_state.int_out = int_src && (next_state.int_hold == 2'h0); // RULE_05

		// break forces the transmit line low over any serial activity
		next_state.txd = c.line_configure[ulmc_pkg::LCR_BREAK_FORCE]
			? 1'b0 : i_tx_serial; // RULE_11

		// rts/cts flow control per transmit mode
		case (ulmc_pkg::ulmc_flow_type'(c.transmit_mode[ulmc_pkg::TMD_FLOW_MODE_HIGH:
				ulmc_pkg::TMD_FLOW_MODE_LOW]))
			ulmc_pkg::ULMC_FLOW_SEMI: begin
				next_state.tx_permit = i_tx_enable && i_cts_active; // RULE_20
				next_state.rts = i_tx_enable;
			end
			ulmc_pkg::ULMC_FLOW_AUTO: begin
				next_state.tx_permit = i_tx_enable && i_cts_active; // RULE_21
				next_state.rts = i_tx_enable && i_tx_data_pending;
			end
			default: begin
				next_state.tx_permit = i_tx_enable; // RULE_19
				next_state.rts = i_rts_manual;
			end
		endcase

		// receive fifo depth and multidrop address recognition
		next_state.rx_fifo_depth = c.internal_mode[ulmc_pkg::IMD_RX_FIFO_DEPTH]
			? ulmc_pkg::RX_FIFO_DEPTH_SINGLE : ulmc_pkg::RX_FIFO_DEPTH_FULL; // RULE_06
		next_state.multidrop = c.internal_mode[ulmc_pkg::IMD_MULTIDROP_MODE];
		next_state.address_char = next_state.multidrop && i_rx_char.valid
			&& i_rx_char.ninth; // RULE_07
		next_state.address_match = next_state.address_char
			&& (i_rx_char.data == i_station_address); // RULE_07

		// loopback versus echo selection and echo filtering
		next_state.local_loop = i_modem_loop_select
			&& !c.internal_mode[ulmc_pkg::IMD_LOOP_ECHO_SELECT]; // RULE_08
		next_state.remote_loop = i_modem_loop_select
			&& c.internal_mode[ulmc_pkg::IMD_LOOP_ECHO_SELECT]; // RULE_08
		echo_on = !i_modem_loop_select
			&& c.internal_mode[ulmc_pkg::IMD_LOOP_ECHO_SELECT]; // RULE_09
		next_state.echo_char = echo_on && i_rx_char.valid
			&& !(c.transmit_mode[ulmc_pkg::TMD_ERROR_ECHO_DISABLE]
				&& i_rx_char.error) // RULE_17
			&& !(c.transmit_mode[ulmc_pkg::TMD_CONTROL_ECHO_DISABLE]
				&& (i_rx_char.control || (next_state.multidrop && i_rx_char.ninth))); // RULE_18

		// parity mode; combinations outside the table give no parity
		pm = {c.line_configure[ulmc_pkg::LCR_PARITY_KIND_HIGH],
			c.line_configure[ulmc_pkg::LCR_PARITY_KIND_LOW],
			c.line_configure[ulmc_pkg::LCR_PARITY_ENABLE]};
		case ({c.transmit_mode[ulmc_pkg::TMD_SOFTWARE_PARITY_FORCE], pm})
			4'h1:    next_state.parity_mode = ulmc_pkg::ULMC_PAR_ODD; // RULE_12
			4'h3:    next_state.parity_mode = ulmc_pkg::ULMC_PAR_EVEN;
			4'h5:    next_state.parity_mode = ulmc_pkg::ULMC_PAR_HIGH;
			4'h7:    next_state.parity_mode = ulmc_pkg::ULMC_PAR_LOW;
			4'h9:    next_state.parity_mode = ulmc_pkg::ULMC_PAR_SOFT;
			default: next_state.parity_mode = ulmc_pkg::ULMC_PAR_NONE;
		endcase
		next_state.sw_parity = (next_state.parity_mode == ulmc_pkg::ULMC_PAR_SOFT); // RULE_13

		// character length: 5 to 8 bits, or 9 with the nine-bit flag
		if (c.transmit_mode[ulmc_pkg::TMD_NINE_BIT_FLAG]) begin
			next_state.char_bits = 4'h9; // RULE_16
		end else begin
			next_state.char_bits = 4'h5 + {2'h0, c.line_configure[ulmc_pkg::LCR_CHAR_LENGTH_HIGH],
				c.line_configure[ulmc_pkg::LCR_CHAR_LENGTH_LOW]}; // RULE_16
		end

		// transmitted stop length in quarter bits
		sbl = {c.transmit_mode[ulmc_pkg::TMD_STOP_LENGTH_BIT_C],
			c.transmit_mode[ulmc_pkg::TMD_STOP_LENGTH_BIT_B],
			c.line_configure[ulmc_pkg::LCR_STOP_LENGTH_BIT_A]};
		case (sbl)
			3'h0:    next_state.stop_quarters = 4'h4;
			3'h1:    next_state.stop_quarters = (next_state.char_bits == 4'h5)
				? 4'h6 : 4'h8; // RULE_14
			3'h2:    next_state.stop_quarters = 4'h3;
			3'h3:    next_state.stop_quarters = 4'h4;
			3'h4:    next_state.stop_quarters = 4'h5;
			3'h5:    next_state.stop_quarters = 4'h6;
			3'h6:    next_state.stop_quarters = 4'h7;
			default: next_state.stop_quarters = 4'h8;
		endcase
	end

	// single state register
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= STATE_RESET; // RULE_02
		end else begin
			state <= next_state;
		end
	end

	// outputs straight from the state register; the minimum receive stop length is a constant
	assign o_avs_readdata = state.readdata;
	assign o_avs_waitrequest = state.waitrequest;
	assign o_cfg = state.cfg;
	assign o_int = state.int_out;
	assign o_txd = state.txd;
	assign o_rts = state.rts;
	assign o_tx_permit = state.tx_permit;
	assign o_rx_fifo_depth = state.rx_fifo_depth;
	assign o_multidrop_mode = state.multidrop;
	assign o_address_char = state.address_char;
	assign o_address_match = state.address_match;
	assign o_local_loop = state.local_loop;
	assign o_remote_loop = state.remote_loop;
	assign o_echo_char = state.echo_char;
	assign o_parity_mode = state.parity_mode;
	assign o_sw_parity = state.sw_parity;
	assign o_stop_quarters = state.stop_quarters;
	assign o_rx_min_stop_quarters = ulmc_pkg::RX_MIN_STOP_QUARTERS; // RULE_15
	assign o_char_bits = state.char_bits;

endmodule // ulmc_top

// ==== ulmc_top_asserts.sv ====
// ulmc_top_asserts: checks on the block's outputs.
// assumes binding into ulmc_top; sees only its ports.
`timescale 1ns/100ps
module ulmc_top_asserts (
	input wire logic                       i_clk,
	input wire logic                       i_rst_n,
	input wire logic                       i_int_service,
	input wire logic                       i_modem_loop_select,
	input wire ulmc_pkg::ulmc_rx_char_type i_rx_char,
	input wire logic                       i_tx_enable,
	input wire logic                       i_tx_data_pending,
	input wire logic                       i_cts_active,
	input wire ulmc_pkg::ulmc_cfg_type     o_cfg,
	input wire logic                       o_int,
	input wire logic                       o_txd,
	input wire logic                       o_rts,
	input wire logic                       o_tx_permit,
	input wire logic [2:0]                 o_rx_fifo_depth,
	input wire logic                       o_local_loop,
	input wire logic                       o_remote_loop,
	input wire logic                       o_echo_char,
	input wire logic                       o_address_char,
	input wire logic [3:0]                 o_char_bits
);
	logic [7:0] im, lc, tm;

	// short names for config bytes
	assign im = o_cfg.internal_mode;
	assign lc = o_cfg.line_configure;
	assign tm = o_cfg.transmit_mode;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	// interrupt low at two edges
	sequence s_int_low2;
		!o_int ##1 !o_int;
	endsequence

	a_break_low: assert property (lc[6] |-> !o_txd)
		else $error("break not on txd");
	a_fifo_depth: assert property (o_rx_fifo_depth == (im[2] ? 3'h1 : 3'h4))
		else $error("fifo depth");
	a_char_size: assert property (o_char_bits == (tm[5] ? 4'h9 : 4'h5 + {2'h0, lc[1:0]}))
		else $error("char length");
	a_auto_ack: assert property (im[3] && i_int_service |=> s_int_low2)
		else $error("auto ack low time");
	a_semi_flow: assert property (tm[4:3] == 2'h2 |-> o_rts == $past(i_tx_enable)
		&& (!o_tx_permit || $past(i_cts_active))) else $error("semi flow");
	a_auto_flow: assert property (tm[4:3] == 2'h3 |->
		o_rts == $past(i_tx_enable && i_tx_data_pending) && (!o_tx_permit || $past(i_cts_active)))
		else $error("auto flow");
	a_loop_kind: assert property (o_local_loop == ($past(i_modem_loop_select) && !im[0])
		&& o_remote_loop == ($past(i_modem_loop_select) && im[0])) else $error("loop kind");
	a_echo_err: assert property (i_rx_char.valid && i_rx_char.error && tm[7] |=> !o_echo_char)
		else $error("error echoed");
	a_echo_ctl: assert property (i_rx_char.valid && i_rx_char.control && tm[6] |=> !o_echo_char)
		else $error("control echoed");
	a_addr_char: assert property (im[1] && i_rx_char.valid && i_rx_char.ninth |=> o_address_char)
		else $error("address missed");
endmodule // ulmc_top_asserts

bind ulmc_top ulmc_top_asserts u_chk (.*);

// ==== ulmc_top_test.sv ====
// ulmc_top_test: self-checking bench of the configuration block.
// assumes the package, design, checker and partner compile first.
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
	$display("Error %s expected %0h seen %0h", nm, ex, got); n_fail++; end end
module ulmc_top_test;
	localparam logic [31:0] STOPS = 32'h8765_4304;
	localparam logic [6:0] PT [6] = '{7'h0E, 7'h11, 7'h33, 7'h25, 7'h67, 7'h79};
	logic i_clk, i_rst_n, rd_s, wr_s, idle, int_req, set_ev, svc, sel, txs, ten, tpend;
	logic rts_man, slow, send, cts, rts, permit, o_wait, o_int, o_txd, o_ll, o_rl, o_echo, swp;
	logic [1:0] kind;
	logic [3:0] be, stopq, minst, bits;
	logic [2:0] depth;
	logic [4:0] addr;
	logic [31:0] wdata, rdata, e, r, ex;
	logic [31:0] q[$];
	ulmc_pkg::ulmc_cfg_type cfg;
	ulmc_pkg::ulmc_parity_type par;
	ulmc_pkg::ulmc_rx_char_type rxc;
	int n_fail, n_checks, n_echo, i, m;

	ulmc_top dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(addr), .i_avs_read(rd_s),
		.i_avs_write(wr_s), .i_avs_writedata(wdata), .i_avs_byteenable(be),
		.o_avs_readdata(rdata), .o_avs_waitrequest(o_wait), .i_device_idle(idle),
		.i_int_request(int_req), .i_int_set_event(set_ev), .i_int_service(svc),
		.i_modem_loop_select(sel), .i_rx_char(rxc), .i_station_address(8'h5A),
		.i_tx_serial(txs), .i_tx_enable(ten), .i_tx_data_pending(tpend), .i_cts_active(cts),
		.i_rts_manual(rts_man), .o_cfg(cfg), .o_int(o_int), .o_txd(o_txd), .o_rts(rts),
		.o_tx_permit(permit), .o_rx_fifo_depth(depth), .o_multidrop_mode(),
		.o_address_char(), .o_address_match(), .o_local_loop(o_ll), .o_remote_loop(o_rl),
		.o_echo_char(o_echo), .o_parity_mode(par), .o_sw_parity(swp), .o_stop_quarters(stopq),
		.o_rx_min_stop_quarters(minst), .o_char_bits(bits));
	ulmc_partner u_far (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_rts(rts), .i_slow(slow),
		.i_send(send), .i_kind(kind), .o_cts(cts), .o_rx_char(rxc));

	// free-running clock
	always #5 i_clk = ~i_clk;

	// answered reads against the oldest note
	always @(posedge i_clk) begin
		if (rd_s && o_wait === 1'b0) begin
			ex = q.pop_front();
			`CHK("readdata", ex, rdata)
		end
	end

	// count echoes
	always @(posedge i_clk) if (o_echo === 1'b1) n_echo++;

	task automatic end_of_test();
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// one access, held until waitrequest low
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
		input logic [3:0] b);
		int k;
		if (!w) q.push_back({24'h0, d});
		@(posedge i_clk);
		wr_s <= w;
		rd_s <= !w;
		addr <= a;
		wdata <= {24'h0, d};
		be <= b;
		for (k = 0; k < 20; k++) begin
			@(posedge i_clk);
			if (o_wait === 1'b0) break;
		end
		wr_s <= 1'b0;
		rd_s <= 1'b0;
		if (k == 20) begin
			n_fail++;
			end_of_test();
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		bus(1'b1, a, d, 4'hF);
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] d);
		bus(1'b0, a, d, 4'hF);
	endtask
	task automatic settle(input int c);
		repeat (c) @(posedge i_clk);
		@(negedge i_clk);
	endtask
	task automatic tx_char(input logic [1:0] kd);
		@(posedge i_clk);
		send <= 1'b1;
		kind <= kd;
		@(posedge i_clk);
		send <= 1'b0;
		repeat (3) @(posedge i_clk);
	endtask

	// main sequence
	initial begin
		i_clk = 0; i_rst_n = 0; rd_s = 0; wr_s = 0; be = 0; addr = 0; wdata = 0; idle = 1;
		int_req = 0; set_ev = 0; svc = 0; sel = 0; txs = 1; ten = 0; tpend = 0; rts_man = 0;
		slow = 0; send = 0; kind = 0; n_fail = 0; n_checks = 0; n_echo = 0;
		r = $urandom(97342);
		repeat (5) @(posedge i_clk);
		i_rst_n <= 1'b1;
		rd(5'h00, 8'h0C);
		rd(5'h04, 8'h00);
		rd(5'h08, 8'h00);
		rd(5'h14, 8'h00);
		settle(0);
		`CHK("depth", 3'h1, depth)
		`CHK("minstop", 4'h3, minst)
		wr(5'h00, 8'hF3);
		rd(5'h00, 8'h03);
		settle(0);
		`CHK("depth", 3'h4, depth)
		@(posedge i_clk);
		idle <= 1'b0;
		wr(5'h04, 8'h03);
		idle <= 1'b1;
		bus(1'b1, 5'h04, 8'h03, 4'h0);
		rd(5'h04, 8'h00);
		for (i = 0; i < 16; i++) begin
			wr(5'h04, {5'h00, i[0], {2{i[3]}}});
			wr(5'h08, {6'h00, i[2:1]});
			settle(1);
			e = (i[2:0] == 3'h1) ? (i[3] ? 4'h8 : 4'h6) : STOPS[i[2:0]*4 +: 4];
			`CHK("stop", e[3:0], stopq)
			`CHK("bits", i[3] ? 4'h8 : 4'h5, bits)
		end
		wr(5'h08, 8'h20);
		settle(1);
		`CHK("bits", 4'h9, bits)
		for (i = 0; i < 6; i++) begin
			wr(5'h04, {2'h0, PT[i][2:0], 3'h0});
			wr(5'h08, {5'h00, PT[i][3], 2'h0});
			settle(1);
			`CHK("parity", PT[i][6:4], par)
			`CHK("swpar", PT[i][6:4] == 3'h7, swp)
		end
		wr(5'h04, 8'h40);
		settle(1);
		`CHK("txd", 1'b0, o_txd)
		wr(5'h04, 8'h80);
		r = $urandom;
		wr(5'h0C, r[7:0]);
		rd(5'h0C, r[7:0]);
		rd(5'h04, 8'h80);
		settle(1);
		`CHK("divisor", r[7:0], cfg.gen_b_divisor[7:0])
		wr(5'h04, 8'h00);
		rd(5'h00, 8'h03);
		settle(1);
		`CHK("txd", 1'b1, o_txd)
		for (m = 0; m < 4; m++) begin
			if (m == 1) continue;
			wr(5'h08, {3'h0, m[1:0], 3'h0});
			repeat (8) begin
				@(posedge i_clk);
				r = $urandom;
				ten <= r[0];
				tpend <= r[1];
				rts_man <= r[2];
				slow <= r[3];
				settle(8);
				`CHK("rts", m == 0 ? rts_man : (m == 2 ? ten : ten & tpend), rts)
				`CHK("permit", m == 0 ? ten : ten & cts, permit)
			end
		end
		wr(5'h00, 8'h08);
		@(posedge i_clk);
		int_req <= 1'b1;
		settle(2);
		`CHK("int", 1'b1, o_int)
		@(posedge i_clk);
		svc <= 1'b1;
		@(posedge i_clk);
		svc <= 1'b0;
		for (i = 0; i < 3; i++) begin
			@(negedge i_clk);
			`CHK("int", i == 2, o_int)
			@(posedge i_clk);
		end
		wr(5'h00, 8'h00);
		set_ev <= 1'b1;
		@(posedge i_clk);
		set_ev <= 1'b0;
		settle(1);
		`CHK("int", 1'b1, o_int)
		wr(5'h10, 8'h02);
		for (i = 0; i < 2; i++) begin
			@(negedge i_clk);
			`CHK("int", 1'b0, o_int)
		end
		tx_char(2'h0);
		wr(5'h00, 8'h03);
		wr(5'h08, 8'hC0);
		for (i = 0; i < 4; i++) tx_char(i[1:0]);
		`CHK("echoes", 1, n_echo)
		sel <= 1'b1;
		settle(1);
		`CHK("remote", 1'b1, o_rl)
		wr(5'h00, 8'h00);
		settle(1);
		`CHK("local", 1'b1, o_ll)
		@(posedge i_clk);
		sel <= 1'b0;
		wr(5'h10, 8'h01);
		rd(5'h00, 8'h0C);
		rd(5'h08, 8'h00);
		wr(5'h04, 8'h1B);
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_rst_n <= 1'b1;
		rd(5'h04, 8'h00);
		end_of_test();
	end
endmodule // ulmc_top_test
